// ### shared/tmcc_defines.svh
`ifndef TMCC_DEFINES_SVH
`define TMCC_DEFINES_SVH

// Register byte offsets, one 32-bit word each
`define TMCC_OFS_CTRL0 8'h00
`define TMCC_OFS_CTRL1 8'h04
`define TMCC_OFS_CNT_LO 8'h08
`define TMCC_OFS_CNT_HI 8'h0C
`define TMCC_OFS_CMPA_LO 8'h10
`define TMCC_OFS_CMPA_HI 8'h14
`define TMCC_OFS_STDCFG 8'h18
`define TMCC_OFS_CAPTURE 8'h1C

// Reset values
`define TMCC_CTRL0_RST 8'h00
`define TMCC_CTRL1_RST 8'h00
`define TMCC_STDCFG_RST 3'h0

// Operating mode codes
`define TMCC_MODE_CMP 2'h0
`define TMCC_MODE_PWM 2'h2
`define TMCC_MODE_TMR 2'h3

// Clock select codes
`define TMCC_CK_SYS4 3'h0
`define TMCC_CK_SYS 3'h1
`define TMCC_CK_H16 3'h2
`define TMCC_CK_H64 3'h3
`define TMCC_CK_SUB0 3'h4
`define TMCC_CK_SUB1 3'h5
`define TMCC_CK_EXTR 3'h6
`define TMCC_CK_EXTF 3'h7

// Capture edge select codes
`define TMCC_CAP_RISE 2'h0
`define TMCC_CAP_FALL 2'h1

// Prescaler taps
`define TMCC_PRE_SYS4 6'h03
`define TMCC_PRE_H16 6'h0F
`define TMCC_PRE_H64 6'h3F

// Subsystem clock: 32768 Hz period in ns, divided from 100 MHz
`define TMCC_CLK_PERIOD_NS 10
`define TMCC_SUB_PERIOD_NS 30518
`define TMCC_SUB_DIV (`TMCC_SUB_PERIOD_NS / `TMCC_CLK_PERIOD_NS)

`define TMCC_CNT_MAX 10'h3FF

`endif

// ### shared/tmcc_pkg.sv
`default_nettype none
package tmcc_pkg;

  typedef struct packed {
    logic pau;
    logic [2:0] ck;
    logic on;
    logic [2:0] rp;
  } tmcc_ctrl0_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic dpx;
    logic cclr;
  } tmcc_ctrl1_t;

  typedef struct packed {
    logic [1:0] cap_edge;
    logic sp_en;
  } tmcc_stdcfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } tmcc_edges_t;

endpackage
`default_nettype wire

// ### hdl/tmcc_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

module tmcc_sync_edge
  import tmcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output var tmcc_edges_t edges_o
);

  logic meta;
  logic sync;
  logic last;

  // Two stages before any logic looks at the pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  always_comb
  begin
    edges_o.rise = sync & ~last;
    edges_o.fall = ~sync & last;
  end

endmodule

`default_nettype wire

// ### hdl/tmcc_core.sv
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tmcc_defines.svh"

// Function
// - Free-running up-counter compared with comparators
// - Match raises interrupt, may clear counter, pin
// - Separate interrupt sources for matches A, P
// - Three-bit field selects counter clock source
// - External pin counts rising or falling edge
// - Standard variant: pin edge triggers single pulse
// - Standard variant: capture pin, two-bit edge select
// - Compare mode: pin high, low or toggle
// - PWM appears on same output pin pair
// - Second output pin is inverse of first
// - Low bytes reached only through holding buffer
// - Compare-A low write fills buffer only
// - High write stores byte, buffer to low
// - High read copies low byte into buffer
// - Low byte read returns buffer contents
// - Modes: compare output, timer, PWM output
// - Counter is ten bits, counting up
// - P compares all ten bits with rp times 128 less one, A all
// - Counter cleared by reset, on-rise, overflow, match only
module tmcc_core
  import tmcc_pkg::*;
#(
  parameter int SUB_DIV = `TMCC_SUB_DIV
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_clock_pin_i,
  input wire logic capture_input_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_inv_o,
  output logic match_a_o,
  output logic match_p_o
);

  tmcc_ctrl0_t ctrl0;
  tmcc_ctrl1_t ctrl1;
  tmcc_stdcfg_t stdcfg;
  tmcc_edges_t ext_edge;
  tmcc_edges_t cap_edge;
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic [9:0] cmpa;
  logic [9:0] cap_val;
  logic [7:0] hold_buf;
  logic [5:0] pre;
  logic [15:0] sub_cnt;
  logic sub_tick;
  logic tick;
  logic on_q;
  logic on_rise;
  logic run;
  logic hit_a;
  logic hit_p;
  logic clr_on_a;
  logic out_raw;
  logic acc;
  logic wr;
  logic rd;
  logic [9:0] p_last;
  logic [9:0] duty;

  // One access per ack; no new access starts in the cycle in which ack is high
  assign acc = cyc_i & stb_i & ~ack_o;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;

  tmcc_sync_edge u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_clock_pin_i),
    .edges_o(ext_edge)
  );

  tmcc_sync_edge u_cap_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_input_pin_i),
    .edges_o(cap_edge)
  );

  // Internal rates come from two free dividers: pre, and sub_cnt for the sub clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre <= 6'h00;
    else
      pre <= pre + 6'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || sub_cnt == 16'(SUB_DIV - 1))
      sub_cnt <= 16'h0000;
    else
      sub_cnt <= sub_cnt + 16'h0001;
  end

  assign sub_tick = (sub_cnt == 16'(SUB_DIV - 1));

  always_comb
  begin
    case (ctrl0.ck)
      `TMCC_CK_SYS4: tick = (pre[1:0] == 2'(`TMCC_PRE_SYS4));
      `TMCC_CK_SYS: tick = 1'b1;
      `TMCC_CK_H16: tick = (pre[3:0] == 4'(`TMCC_PRE_H16));
      `TMCC_CK_H64: tick = (pre == `TMCC_PRE_H64);
      `TMCC_CK_SUB0: tick = sub_tick;
      `TMCC_CK_SUB1: tick = sub_tick;
      `TMCC_CK_EXTR: tick = ext_edge.rise;
      `TMCC_CK_EXTF: tick = ext_edge.fall;
      default: tick = 1'b0;
    endcase
  end

  // Comparators; P period is 128 clocks per step, zero means full wrap
  assign p_last = {ctrl0.rp, 7'h00} - 10'h001;
  assign hit_a = (cnt == cmpa);
  assign hit_p = (cnt == p_last);
  assign on_rise = ctrl0.on & ~on_q;
  assign run = ctrl0.on & ~ctrl0.pau & tick;
  // PWM picks the period source from the duplex bit
  assign clr_on_a = (ctrl1.mode == `TMCC_MODE_PWM) ? ctrl1.dpx
                                                    : ctrl1.cclr;
  assign duty = ctrl1.dpx ? {ctrl0.rp, 7'h00} : cmpa;

  always_comb
  begin
    next_cnt = cnt;
    if (on_rise)
      next_cnt = 10'h000;
    else if (run)
    begin
      if ((clr_on_a ? hit_a : hit_p) || cnt == `TMCC_CNT_MAX)
        next_cnt = 10'h000;
      else
        next_cnt = cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 10'h000;
      on_q <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      on_q <= ctrl0.on;
    end
  end

  // Match pulses serve as the two interrupt requests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      match_a_o <= 1'b0;
      match_p_o <= 1'b0;
    end
    else
    begin
      match_a_o <= run & hit_a & ~on_rise;
      match_p_o <= run & hit_p & ~on_rise;
    end
  end

  // Output level before polarity; timer mode only loads oc on enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_raw <= 1'b0;
    else if (on_rise)
      out_raw <= ctrl1.oc;
    else
    begin
      case (ctrl1.mode)
        `TMCC_MODE_CMP:
          if (run && hit_a)
          begin
            case (ctrl1.io)
              2'h1: out_raw <= 1'b0;
              2'h2: out_raw <= 1'b1;
              2'h3: out_raw <= ~out_raw;
              default: out_raw <= out_raw;
            endcase
          end
        `TMCC_MODE_PWM:
          case (ctrl1.io)
            2'h0: out_raw <= ~ctrl1.oc;
            2'h1: out_raw <= ctrl1.oc;
            2'h2: out_raw <= (next_cnt < duty) ? ctrl1.oc : ~ctrl1.oc;
            default: out_raw <= out_raw;
          endcase
        default: out_raw <= out_raw;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_output_pin_o <= 1'b0;
      timer_output_pin_inv_o <= 1'b1;
    end
    else
    begin
      timer_output_pin_o <= out_raw ^ ctrl1.pol;
      timer_output_pin_inv_o <= ~(out_raw ^ ctrl1.pol);
    end
  end

  // Capture on the selected edge of the capture pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_val <= 10'h000;
    else
    begin
      case (stdcfg.cap_edge)
        `TMCC_CAP_RISE: if (cap_edge.rise) cap_val <= cnt;
        `TMCC_CAP_FALL: if (cap_edge.fall) cap_val <= cnt;
        default: if (cap_edge.rise || cap_edge.fall) cap_val <= cnt;
      endcase
    end
  end

  // Control registers; a single-pulse trigger beats a write of on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl0 <= `TMCC_CTRL0_RST;
      ctrl1 <= `TMCC_CTRL1_RST;
      stdcfg <= `TMCC_STDCFG_RST;
    end
    else
    begin
      if (wr && adr_i == `TMCC_OFS_CTRL0)
        ctrl0 <= dat_i[7:0];
      if (wr && adr_i == `TMCC_OFS_CTRL1)
        ctrl1 <= dat_i[7:0];
      if (wr && adr_i == `TMCC_OFS_STDCFG)
        stdcfg <= dat_i[2:0];
      if (stdcfg.sp_en && ext_edge.rise)
        ctrl0.on <= 1'b1;
    end
  end

  // Low bytes pass through one shared buffer; order is software's job
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_buf <= 8'h00;
      cmpa <= 10'h000;
    end
    else
    begin
      if (wr && adr_i == `TMCC_OFS_CMPA_LO)
        hold_buf <= dat_i[7:0];
      if (wr && adr_i == `TMCC_OFS_CMPA_HI)
        cmpa <= {dat_i[1:0], hold_buf};
      if (rd && adr_i == `TMCC_OFS_CNT_HI)
        hold_buf <= cnt[7:0];
      if (rd && adr_i == `TMCC_OFS_CMPA_HI)
        hold_buf <= cmpa[7:0];
    end
  end

  // Classic slave: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= acc;
      dat_o <= 32'h0000_0000;
      if (rd)
      begin
        case (adr_i)
          `TMCC_OFS_CTRL0: dat_o[7:0] <= ctrl0;
          `TMCC_OFS_CTRL1: dat_o[7:0] <= ctrl1;
          `TMCC_OFS_CNT_LO: dat_o[7:0] <= hold_buf;
          `TMCC_OFS_CNT_HI: dat_o[1:0] <= cnt[9:8];
          `TMCC_OFS_CMPA_LO: dat_o[7:0] <= hold_buf;
          `TMCC_OFS_CMPA_HI: dat_o[1:0] <= cmpa[9:8];
          `TMCC_OFS_STDCFG: dat_o[2:0] <= stdcfg;
          `TMCC_OFS_CAPTURE: dat_o[9:0] <= cap_val;
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_on_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl0.on && !on_q) |=> (cnt == 10'h000))
    else $error("counter not cleared on enable");
  a_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run && !(ctrl0.on && !on_q)) |=> $stable(cnt))
    else $error("counter moved without a tick");
  a_match_a_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && cnt == cmpa && on_q) |=> match_a_o)
    else $error("match A pulse missing");
  a_match_p_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && on_q && cnt == p_last && !clr_on_a) |=> match_p_o && cnt == 0)
    else $error("period match did not clear");
  a_pin_inverse: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_output_pin_inv_o == !timer_output_pin_o)
    else $error("inverse pin not inverted");
  a_low_write_buf: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == `TMCC_OFS_CMPA_LO) |=> $stable(cmpa))
    else $error("low write changed compare A");
  a_high_write_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == `TMCC_OFS_CMPA_HI)
      |=> cmpa == {$past(dat_i[1:0]), $past(hold_buf)})
    else $error("compare A pair write wrong");
  a_high_read_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == `TMCC_OFS_CNT_HI)
      |=> hold_buf == $past(cnt[7:0]) && dat_o[1:0] == $past(cnt[9:8]))
    else $error("counter high read did not latch");
  a_low_read_buf: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == `TMCC_OFS_CNT_LO) |=> dat_o[7:0] == $past(hold_buf))
    else $error("low read not from buffer");
  a_cmp_set_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl1.mode == `TMCC_MODE_CMP && ctrl1.io == 2'h2 && run && hit_a
      && on_q) |=> out_raw ##1 (timer_output_pin_o == !ctrl1.pol))
    else $error("compare set-high failed");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle");

  c_match_a: cover property (@(posedge clk_i) disable iff (rst_i)
    match_a_o);
  c_match_p: cover property (@(posedge clk_i) disable iff (rst_i)
    match_p_o);
  c_pwm_active: cover property (@(posedge clk_i) disable iff (rst_i)
    ctrl1.mode == `TMCC_MODE_PWM && ctrl1.io == 2'h2 && out_raw);
  c_ext_count: cover property (@(posedge clk_i) disable iff (rst_i)
    run && ctrl0.ck == `TMCC_CK_EXTF);

endmodule

`default_nettype wire

// ### verif/tmcc_ext_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmcc_ext_pin_model
(
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [7:0] high_len_i,
  output logic pin_o
);
  logic [7:0] left;
  // Source stays low between pulses
  initial pin_o = 1'b0;
  initial left = 8'h00;
  always @(posedge clk_i)
  begin
    if (fire_i)
    begin
      pin_o <= 1'b1;
      left <= high_len_i;
    end
    else if (left > 8'h01)
      left <= left - 8'h01;
    else
      pin_o <= 1'b0;
  end
endmodule
`default_nettype wire

// ### verif/timer_module_common_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module timer_module_common_core_tb_top;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} tmcc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic fire = 1'b0;
  logic cap = 1'b0;
  logic pin;
  logic [31:0] rdat;
  logic ack, tp, tpn, ma, mp;
  logic [7:0] q, v;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  int gaps [6] = '{8, 2, 32, 128, 8, 8};
  tmcc_row_t rows [9] = '{'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00},
    '{1'b1, 8'h04, 8'h5A}, '{1'b0, 8'h04, 8'h5A}, '{1'b1, 8'h04, 8'h00},
    '{1'b1, 8'h00, 8'h47}, '{1'b0, 8'h00, 8'h47}, '{1'b0, 8'h20, 8'h00},
    '{1'b0, 8'h18, 8'h00}};

  always #5 clk = ~clk;

  tmcc_core #(.SUB_DIV(4)) dut (.clk_i(clk), .rst_i(rst), .adr_i(adr),
    .dat_i(wdat), .sel_i(4'hF), .we_i(we), .cyc_i(cyc), .stb_i(stb),
    .dat_o(rdat), .ack_o(ack), .ext_clock_pin_i(pin),
    .capture_input_pin_i(cap), .timer_output_pin_o(tp),
    .timer_output_pin_inv_o(tpn), .match_a_o(ma), .match_p_o(mp));

  tmcc_ext_pin_model ext (.clk_i(clk), .fire_i(fire), .high_len_i(8'h0A),
    .pin_o(pin));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic gap(input bit p, output int k);
    k = 0;
    do @(posedge clk); while ((p ? mp : ma) !== 1'b1);
    do
    begin
      @(posedge clk);
      k++;
    end
    while ((p ? mp : ma) !== 1'b1);
  endtask

  task automatic done(input string s);
    $display("test %s ended, errors %0d", s, num_errors);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs a few thousand cycles
  initial
  begin
    #300000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk(tp, 1'b0);
    chk(tpn, 1'b1);
    @(posedge clk);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
      begin
        wb(1'b0, rows[i].a, 8'h00, q);
        chk(q, rows[i].d);
      end
    end
    wr(8'h00, 8'h00);
    done("regs");
    wr(8'h10, 8'h5A);
    wb(1'b0, 8'h14, 8'h00, q);
    chk(q, 8'h00);
    wb(1'b0, 8'h10, 8'h00, q);
    chk(q, 8'h00);
    wr(8'h10, 8'h5A);
    wr(8'h14, 8'h02);
    wb(1'b0, 8'h14, 8'h00, q);
    chk(q, 8'h02);
    wb(1'b0, 8'h10, 8'h00, q);
    chk(q, 8'h5A);
    done("buffer");
    wr(8'h10, 8'h05);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'h31);
    wr(8'h00, 8'h18);
    gap(1'b0, n);
    gap(1'b0, n);
    chk(n, 6);
    repeat (2) @(posedge clk);
    v[0] = tp;
    // One full period holds exactly one toggle
    repeat (6) @(posedge clk);
    chk(tp, !v[0]);
    chk(tpn, !tp);
    wr(8'h00, 8'h10);
    wb(1'b0, 8'h0C, 8'h00, q);
    wb(1'b0, 8'h08, 8'h00, v);
    chk(q, 8'h00);
    chk(v < 8'h06, 1'b1);
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'h03);
    wb(1'b0, 8'h0C, 8'h00, q);
    wb(1'b0, 8'h08, 8'h00, q);
    chk(q, v);
    done("compare");
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'h01);
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h00, 8'h00);
      wr(8'h00, {1'b0, 3'(k), 4'h8});
      gap(1'b0, n);
      gap(1'b0, n);
      chk(n, gaps[k]);
    end
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h19);
    gap(1'b1, n);
    gap(1'b1, n);
    chk(n, 128);
    done("clocks");
    // Frozen count; capture on falling edge only
    wr(8'h00, 8'h00);
    wb(1'b0, 8'h0C, 8'h00, q);
    wb(1'b0, 8'h08, 8'h00, v);
    wr(8'h18, 8'h02);
    cap <= 1'b1;
    repeat (6) @(posedge clk);
    wb(1'b0, 8'h1C, 8'h00, q);
    chk(q, 8'h00);
    cap <= 1'b0;
    repeat (6) @(posedge clk);
    wb(1'b0, 8'h1C, 8'h00, q);
    chk(q, v);
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h21);
    wr(8'h00, 8'h18);
    gap(1'b0, n);
    chk(n, 2);
    repeat (2) @(posedge clk);
    chk(tp, 1'b1);
    wr(8'h00, 8'h10);
    wr(8'h18, 8'h01);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (6) @(posedge clk);
    wb(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h18);
    wr(8'h18, 8'h00);
    done("capture");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'h01);
    for (int e = 6; e < 8; e++)
    begin
      wr(8'h00, 8'h00);
      wr(8'h00, {1'b0, 3'(e), 4'h8});
      repeat (8) @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      n = 1;
      while (ma !== 1'b1 && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      chk(e == 6 ? n < 8 : n >= 10 && n < 30, 1'b1);
    end
    done("ext");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h20);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'hA8);
    wr(8'h00, 8'h19);
    repeat (200) @(posedge clk);
    n = 0;
    repeat (128)
    begin
      @(posedge clk);
      if (tp === 1'b1)
        n++;
    end
    chk(n, 32);
    chk(tpn, !tp);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'hC0);
    wr(8'h00, 8'h19);
    gap(1'b0, n);
    v[0] = tp;
    gap(1'b0, n);
    chk(n, 128);
    chk(tp, v[0]);
    done("pwm");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h04, 8'h00, q);
    chk(q, 8'h00);
    chk(tp, 1'b0);
    chk(tpn, 1'b1);
    done("reset");
    end_sim();
  end
endmodule
`default_nettype wire
